//--- core/regulator_fault_flags.sv
// Latched regulator and supply-monitor fault flags, read over an AXI4-Lite slave.
// Assumes the comparator outputs and the reset pin level arrive asynchronously from analog
// and pad logic; mode indications come from logic on the same clock.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module regulator_fault_flags
import fault_flag_pkg::*;
#(
   parameter int FILTER_LEN      = fault_flag_pkg::FILTER_CYCLES,
   parameter int SHORT_RESET_LEN = fault_flag_pkg::SHORT_RESET_CYCLES
)
(
   input  wire logic                              clk,
   input  wire logic                              srst,
   // Comparator and monitor levels, active high while the fault condition is present; resetPinLevel is low active.
   input  wire logic                              auxUnderVoltage,
   input  wire logic                              auxOverCurrent,
   input  wire logic                              canSupplyOverTemp,
   input  wire logic                              canSupplyUnderVoltage,
   input  wire logic                              canSupplyOverCurrent,
   input  wire logic                              senseInputBelow,
   input  wire logic                              primarySupplyBelow,
   input  wire logic                              logicSupplyOverCurrent,
   input  wire logic                              logicSupplyOverCurrentLp,
   input  wire logic                              logicSupplyThermalOff,
   input  wire logic                              resetPinLevel,
   input  wire logic                              primarySupplyBatFail,
   // Operating mode from the mode controller.
   input  wire logic                              normalMode,
   input  wire logic                              lowPowerVddOnMode,
   // Latched flags, for the SPI frame builder.
   output logic [fault_flag_pkg::NUM_FLAGS-1:0]   flags,
   // AXI4-Lite slave.
   input  wire logic [fault_flag_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                              awvalid,
   output logic                                   awready,
   input  wire logic [31:0]                       wdata,
   input  wire logic [3:0]                        wstrb,
   input  wire logic                              wvalid,
   output logic                                   wready,
   output logic [1:0]                             bresp,
   output logic                                   bvalid,
   input  wire logic                              bready,
   input  wire logic [fault_flag_pkg::ADDR_W-1:0] araddr,
   input  wire logic                              arvalid,
   output logic                                   arready,
   output logic [31:0]                            rdata,
   output logic [1:0]                             rresp,
   output logic                                   rvalid,
   input  wire logic                              rready
);

   import fault_flag_pkg::*;

   localparam int SR_CNT_W = $clog2(SHORT_RESET_LEN + 2);
   localparam logic [SR_CNT_W-1:0] SR_LIMIT = SR_CNT_W'(SHORT_RESET_LEN);

   // Two-stage synchronisers for every asynchronous level.
   logic [NUM_FLAGS-1:0] asyncIn;
   logic [NUM_FLAGS-1:0] meta_ff;
   logic [NUM_FLAGS-1:0] sync_ff;

   assign asyncIn = {primarySupplyBatFail, resetPinLevel, logicSupplyThermalOff,
                     logicSupplyOverCurrentLp, logicSupplyOverCurrent, primarySupplyBelow,
                     senseInputBelow, canSupplyOverCurrent, canSupplyUnderVoltage,
                     canSupplyOverTemp, auxOverCurrent, auxUnderVoltage};

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_ff <= SYNC_RESET;
         sync_ff <= SYNC_RESET;
      end
      else
      begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
      end
   end

   // The reset pin is low active; its synchroniser starts at the idle high level, so
   // leaving srst never looks like the end of a short low pulse.
   logic pinLow;
   logic pinLowPrev_ff;
   logic pinReleased;

   assign pinLow      = ~sync_ff[BIT_SHORT_RST];
   assign pinReleased = pinLowPrev_ff & ~pinLow;

   // Low-pulse length, saturating just past the short-pulse limit.
   logic [SR_CNT_W-1:0] lowCnt_ff;
   logic [SR_CNT_W-1:0] nxt_lowCnt;
   logic                lowSaturated;
   logic                shortPulseSeen;

   assign lowSaturated   = (lowCnt_ff > SR_LIMIT);
   assign nxt_lowCnt     = !pinLow ? '0 : (lowSaturated ? lowCnt_ff : lowCnt_ff + SR_CNT_W'(1));
   // A pulse is short if it ended before lasting the full limit.
   assign shortPulseSeen = pinReleased & (lowCnt_ff < SR_LIMIT); // R12

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pinLowPrev_ff <= 1'b0;
         lowCnt_ff     <= '0;
      end
      else
      begin
         pinLowPrev_ff <= pinLow;
         lowCnt_ff     <= nxt_lowCnt;
      end
   end

   // Set conditions and hold conditions for each flag.
   logic [NUM_FLAGS-1:0] setCond;
   logic [NUM_FLAGS-1:0] holdCond;
   logic [NUM_FLAGS-1:0] liveCond;

   assign setCond[BIT_AUX_UV]      = sync_ff[BIT_AUX_UV]; // R1
   assign setCond[BIT_AUX_OC]      = sync_ff[BIT_AUX_OC]; // R2
   assign setCond[BIT_CAN_OT]      = sync_ff[BIT_CAN_OT]; // R4
   assign setCond[BIT_CAN_UV]      = sync_ff[BIT_CAN_UV]; // R5
   assign setCond[BIT_CAN_OC]      = sync_ff[BIT_CAN_OC]; // R6
   assign setCond[BIT_SENSE_LOW]   = sync_ff[BIT_SENSE_LOW]; // R7
   assign setCond[BIT_BATT_UV]     = sync_ff[BIT_BATT_UV]; // R8
   assign setCond[BIT_LOGIC_OC_NM] = sync_ff[BIT_LOGIC_OC_NM] & normalMode; // R9
   assign setCond[BIT_LOGIC_OC_LP] = sync_ff[BIT_LOGIC_OC_LP] & lowPowerVddOnMode; // R10
   assign setCond[BIT_LOGIC_OT]    = sync_ff[BIT_LOGIC_OT]; // R11
   assign setCond[BIT_SHORT_RST]   = shortPulseSeen; // R12
   assign setCond[BIT_BATT_FAIL]   = sync_ff[BIT_BATT_FAIL]; // R14

   // The mode-gated overcurrent flags clear once the current itself is below threshold,
   // whatever the mode; the short-reset flag is held while the pin is still low.
   assign holdCond[BIT_SHORT_RST-1:0]         = sync_ff[BIT_SHORT_RST-1:0]; // R3
   assign holdCond[BIT_SHORT_RST]             = pinLow; // R13
   assign holdCond[NUM_FLAGS-1:BIT_SHORT_RST+1] = sync_ff[NUM_FLAGS-1:BIT_SHORT_RST+1];

   assign liveCond = {sync_ff[NUM_FLAGS-1:BIT_SHORT_RST+1], pinLow, sync_ff[BIT_SHORT_RST-1:0]};

   // Register file state.
   logic [NUM_FLAGS-1:0] enable_ff;
   logic                 flagReadClear;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++)
      begin : g_flag
         flag_latch
         #(
            .FILTER_CYCLES (FILTERED_MASK[gi] ? FILTER_LEN : 0)
         )
         u_latch
         (
            .clk       (clk),
            .srst      (srst),
            .enable    (enable_ff[gi]),
            .cond      (setCond[gi]),
            .hold      (holdCond[gi]),
            .readClear (flagReadClear),
            .flag      (flags[gi])
         );
      end
   endgenerate

   // Write channel: address and data are taken independently and the response
   // follows once both have arrived, held or taken in the same cycle.
   logic                  awHeld_ff;
   logic                  wHeld_ff;
   logic [ADDR_W-1:0]     awAddr_ff;
   logic [31:0]           wData_ff;
   logic [3:0]            wStrb_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  awTake;
   logic                  wTake;
   logic                  doWrite;
   logic [ADDR_W-1:0]     wrAddr;
   logic [31:0]           wrData;
   logic [3:0]            wrStrb;
   logic                  wrHitEnable;
   logic                  wrOkay;
   logic [NUM_FLAGS-1:0]  nxt_enable;

   assign awready = ~awHeld_ff & ~bvalid_ff;
   assign wready  = ~wHeld_ff & ~bvalid_ff;
   assign awTake  = awvalid & awready;
   assign wTake   = wvalid & wready;
   assign doWrite = (awHeld_ff | awTake) & (wHeld_ff | wTake) & ~bvalid_ff;
   assign wrAddr  = awHeld_ff ? awAddr_ff : awaddr;
   assign wrData  = wHeld_ff ? wData_ff : wdata;
   assign wrStrb  = wHeld_ff ? wStrb_ff : wstrb;

   assign wrHitEnable = (wrAddr == OFS_ENABLE);
   // Flag and live registers are read-only, so a write to them is refused as well.
   assign wrOkay      = wrHitEnable;
   assign nxt_enable  = {wrStrb[1] ? wrData[NUM_FLAGS-1:8] : enable_ff[NUM_FLAGS-1:8],
                         wrStrb[0] ? wrData[7:0] : enable_ff[7:0]};

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         awAddr_ff <= '0;
         wData_ff  <= '0;
         wStrb_ff  <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
         enable_ff <= ENABLE_RESET;
      end
      else
      begin
         if (doWrite)
         begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wrOkay ? RESP_OKAY : RESP_SLVERR;
            if (wrHitEnable)
            begin
               enable_ff <= nxt_enable;
            end
         end
         else
         begin
            if (awTake)
            begin
               awHeld_ff <= 1'b1;
               awAddr_ff <= awaddr;
            end
            if (wTake)
            begin
               wHeld_ff <= 1'b1;
               wData_ff <= wdata;
               wStrb_ff <= wstrb;
            end
            if (bvalid_ff & bready)
            begin
               bvalid_ff <= 1'b0;
            end
         end
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp  = bresp_ff;

   // Read channel: one read at a time, answered the cycle after the address is taken.
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        arTake;
   logic        rdHitFlags;
   logic        rdHitLive;
   logic        rdHitEnable;
   logic [31:0] rdMux;

   assign arready     = ~rvalid_ff;
   assign arTake      = arvalid & arready;
   assign rdHitFlags  = (araddr == OFS_FLAGS);
   assign rdHitLive   = (araddr == OFS_LIVE);
   assign rdHitEnable = (araddr == OFS_ENABLE);
   assign rdMux       = rdHitFlags  ? 32'(flags) :
                        rdHitLive   ? 32'(liveCond) :
                        rdHitEnable ? 32'(enable_ff) : 32'h0000_0000;
   // Reading the flag word is the host's acknowledge; the returned word is the
   // value before clearing, and any flag set in that same cycle survives.
   assign flagReadClear = arTake & rdHitFlags;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= RESP_OKAY;
      end
      else if (arTake)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rdMux;
         rresp_ff  <= (rdHitFlags | rdHitLive | rdHitEnable) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
      begin
         rvalid_ff <= 1'b0;
      end
   end

   assign rvalid = rvalid_ff;
   assign rdata  = rdata_ff;
   assign rresp  = rresp_ff;

endmodule : regulator_fault_flags

`default_nettype wire

//--- core/fault_flag_pkg.sv
// Constants shared by the regulator fault flag bank: register map, flag layout and timing.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
// Functional notes
// R1: Aux undervoltage flag sets after 100 us below threshold; clears on recovery plus read.
// R2: Aux overcurrent flag sets after current stays above threshold over 100 us.
// R3: Aux overcurrent flag holds until current is below threshold and flag is read.
// R4: CAN supply thermal flag sets when hot; clears after cooling and read.
// R5: CAN supply undervoltage flag sets after 100 us low; clears on recovery and read.
// R6: CAN supply overcurrent flag sets after 100 us; clears on recovery and read.
// R7: Sense input low flag sets after 100 us low; clears on recovery and read.
// R8: Battery undervoltage flag sets after 100 us low; clears on recovery and read.
// R9: Logic supply overcurrent flag sets only in Normal mode after 100 us.
// R10: Low-power overcurrent flag sets in low-power supply-on mode after 100 us.
// R11: Logic supply thermal flag sets on thermal switch-off; clears after recovery and read.
// R12: Short reset flag sets when reset pin low pulse is under 100 ms.
// R13: Short reset flag clears only after the pulse ended and flag read.
// R14: Battery fail flag sets below fail threshold; clears after recovery and read.
// R15: Persistence filters restart whenever the condition drops before the filter time.

package fault_flag_pkg;

   localparam int CLK_MHZ            = 200;
   localparam int FILTER_TIME_US     = 100;
   localparam int FILTER_CYCLES      = FILTER_TIME_US * CLK_MHZ;
   localparam int SHORT_RESET_MS     = 100;
   localparam int SHORT_RESET_CYCLES = SHORT_RESET_MS * 1000 * CLK_MHZ;

   localparam int NUM_FLAGS = 12;

   // Flag positions in the flag, live-condition and enable registers.
   localparam int BIT_AUX_UV      = 0;
   localparam int BIT_AUX_OC      = 1;
   localparam int BIT_CAN_OT      = 2;
   localparam int BIT_CAN_UV      = 3;
   localparam int BIT_CAN_OC      = 4;
   localparam int BIT_SENSE_LOW   = 5;
   localparam int BIT_BATT_UV     = 6;
   localparam int BIT_LOGIC_OC_NM = 7;
   localparam int BIT_LOGIC_OC_LP = 8;
   localparam int BIT_LOGIC_OT    = 9;
   localparam int BIT_SHORT_RST   = 10;
   localparam int BIT_BATT_FAIL   = 11;

   // Flags whose set condition passes through the persistence filter.
   localparam logic [NUM_FLAGS-1:0] FILTERED_MASK = 12'h1FB;

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LIVE   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h08;

   localparam logic [NUM_FLAGS-1:0] ENABLE_RESET = 12'hFFF;

   // The reset pin idles high, so its synchroniser bit starts high and no false pulse follows reset.
   localparam logic [NUM_FLAGS-1:0] SYNC_RESET = 12'h400;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fault_flag_pkg

//--- core/flag_latch.sv
// One latched diagnostic flag with an optional persistence filter and read-to-clear.
// Assumes cond and hold are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module flag_latch
#(
   parameter int FILTER_CYCLES = 20000,
   parameter int CNT_W         = $clog2(FILTER_CYCLES + 2)
)
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic enable,
   input  wire logic cond,
   input  wire logic hold,
   input  wire logic readClear,
   output logic      flag
);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic             flag_ff;
   logic             nxt_flag;
   logic             atLimit;
   logic             setNow;

   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(FILTER_CYCLES);

   assign atLimit = (cnt_ff == LIMIT);
   // The count restarts from zero as soon as the condition drops, so short glitches never set.
   assign nxt_cnt = !cond ? '0 : (atLimit ? cnt_ff : cnt_ff + CNT_W'(1)); // R15
   assign setNow  = enable & cond & atLimit;
   // A set in the same cycle as a read wins over the clear.
   assign nxt_flag = setNow | (flag_ff & ~(readClear & ~hold));

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_ff  <= '0;
         flag_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= nxt_cnt;
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;

endmodule : flag_latch

`default_nettype wire

//--- bench/regulator_flag_properties.sv
// Concurrent checks on the ports of the regulator fault flag bank.
// Assumes the bank is built with a persistence filter length of 8 cycles.
`timescale 1ns/1ps
`default_nettype none

module regulator_flag_checker
import fault_flag_pkg::*;
(
   input wire logic                              clk,
   input wire logic                              srst,
   input wire logic                              auxUnderVoltage,
   input wire logic                              primarySupplyBatFail,
   input wire logic                              normalMode,
   input wire logic [fault_flag_pkg::NUM_FLAGS-1:0] flags,
   input wire logic                              awvalid,
   input wire logic                              awready,
   input wire logic                              wvalid,
   input wire logic                              wready,
   input wire logic                              bvalid,
   input wire logic [fault_flag_pkg::ADDR_W-1:0] araddr,
   input wire logic                              arvalid,
   input wire logic                              arready,
   input wire logic [31:0]                       rdata,
   input wire logic [1:0]                        rresp,
   input wire logic                              rvalid,
   input wire logic                              rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // The input passes two sync flops before the filter, so the samples four and nine cycles earlier must both show it.
   a_uv_filter_held: assert property ($rose(flags[0]) |-> $past(auxUnderVoltage, 4) && $past(auxUnderVoltage, 9))
      else $error("aux undervoltage flag set without a held condition");
   a_clear_on_read: assert property ((|($past(flags) & ~flags)) && !$past(srst) |->
      $past(arvalid && arready && araddr == OFS_FLAGS))
      else $error("flag cleared without a flag read");
   a_batfail_sets: assert property (primarySupplyBatFail [*5] |=> flags[11])
      else $error("battery fail flag not set");
   a_normal_gate: assert property ($rose(flags[7]) |-> $past(normalMode))
      else $error("normal mode overcurrent flag set outside normal mode");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write not answered");
   a_rdata_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before it was taken");
   a_ar_refused: assert property (rvalid |-> !arready)
      else $error("read address accepted while an answer is pending");
endmodule : regulator_flag_checker

bind regulator_fault_flags regulator_flag_checker chk (.clk(clk), .srst(srst), .auxUnderVoltage(auxUnderVoltage),
   .primarySupplyBatFail(primarySupplyBatFail), .normalMode(normalMode), .flags(flags), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

`default_nettype wire

//--- bench/host_bus_model.sv
// Host side of the register bus: one AXI4-Lite write or read at a time.
// Assumes the caller starts each task just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
   input  wire logic       clk,
   output logic [7:0]      awaddr,
   output logic            awvalid,
   input  wire logic       awready,
   output logic [31:0]     wdata,
   output logic [3:0]      wstrb,
   output logic            wvalid,
   input  wire logic       wready,
   input  wire logic       bvalid,
   output logic            bready,
   output logic [7:0]      araddr,
   output logic            arvalid,
   input  wire logic       arready,
   input  wire logic       rvalid,
   output logic            rready
);
   int timeouts = 0;

   initial
   begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
   end

   // Handshakes are judged at the falling edge, where every level is settled.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int n;
      tb = 1'b0;
      n = 0;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      while (!tb && n < 100)
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         n++;
      end
      if (!tb) timeouts++;
   endtask : wr

   // A slow host raises rready only after dly cycles.
   task automatic rd(input logic [7:0] a, input int dly);
      logic ta, tr;
      int n;
      tr = 1'b0;
      n = 0;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 1'b1, dly == 0};
      while (!tr && n < 100)
      begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr || n + 1 == dly) rready <= !tr;
         n++;
      end
      if (!tr) timeouts++;
   endtask : rd
endmodule : host_bus_model

`default_nettype wire

//--- bench/regulator_fault_flag_latches_bench.sv
// Self-checking bench for the regulator fault flag bank, with a short filter.
// Assumes the host model in host_bus_model.sv and the bound property checker.
`timescale 1ns/1ps
`default_nettype none

module regulator_fault_flag_latches_bench;
import fault_flag_pkg::*;
   logic clk = 1'b0, srst = 1'b1, normalMode = 1'b1, lowPowerVddOnMode = 1'b1;
   logic [11:0] cond = 12'h000;
   wire logic [11:0] flags;
   wire logic [7:0] awaddr, araddr;
   wire logic [31:0] wdata, rdata;
   wire logic [3:0] wstrb;
   wire logic [1:0] bresp, rresp;
   wire logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [33:0] readQ[$];
   logic [1:0] respQ[$];
   int errCount = 0, numChecks = 0;

   always #2.5 clk = ~clk;

   // Bit i of cond drives the monitor behind flag i; bit 10 pulls the reset pin low.
   regulator_fault_flags #(.FILTER_LEN(8), .SHORT_RESET_LEN(50)) uut (.clk(clk), .srst(srst),
      .auxUnderVoltage(cond[0]), .auxOverCurrent(cond[1]), .canSupplyOverTemp(cond[2]),
      .canSupplyUnderVoltage(cond[3]), .canSupplyOverCurrent(cond[4]), .senseInputBelow(cond[5]),
      .primarySupplyBelow(cond[6]), .logicSupplyOverCurrent(cond[7]), .logicSupplyOverCurrentLp(cond[8]),
      .logicSupplyThermalOff(cond[9]), .resetPinLevel(!cond[10]), .primarySupplyBatFail(cond[11]),
      .normalMode(normalMode), .lowPowerVddOnMode(lowPowerVddOnMode), .flags(flags), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   host_bus_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

   task automatic fail(input logic [33:0] got, input logic [33:0] exp);
      errCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
   endtask : fail

   task automatic chk_word(input logic [33:0] got, input logic [33:0] exp);
      numChecks++;
      if (got !== exp) fail(got, exp);
   endtask : chk_word

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      numChecks++;
      if (got !== exp) fail({32'h0, got}, {32'h0, exp});
   endtask : chk_resp

   task automatic chk_flags(input logic [11:0] exp);
      @(negedge clk);
      numChecks++;
      if (flags !== exp) fail({22'h0, flags}, {22'h0, exp});
   endtask : chk_flags

   // Answers are compared in arrival order against the notes left by the driver.
   always @(posedge clk)
   begin
      if (rvalid && rready) chk_word({rresp, rdata}, readQ.size() ? readQ.pop_front() : 34'h3FFFFFFFF);
      if (bvalid && bready) chk_resp(bresp, respQ.size() ? respQ.pop_front() : 2'h3);
   end

   task automatic rchk(input logic [7:0] a, input logic [11:0] d, input logic [1:0] r);
      readQ.push_back({r, 20'h0, d});
      host.rd(a, $urandom % 3);
   endtask : rchk

   task automatic wchk(input logic [7:0] a, input logic [11:0] d, input logic [1:0] r);
      respQ.push_back(r);
      host.wr(a, {20'h0, d});
   endtask : wchk

   task automatic hold(input logic [11:0] v, input int n);
      @(posedge clk);
      cond <= v;
      repeat (n) @(posedge clk);
   endtask : hold

   task automatic flag_case(input int i);
      logic [11:0] b;
      b = 12'h001 << i;
      if (FILTERED_MASK[i])
      begin
         hold(b, $urandom % 7 + 1);
         hold(12'h000, 20);
         chk_flags(12'h000);
      end
      hold(b, 20);
      chk_flags(i == 10 ? 12'h000 : b);
      rchk(OFS_LIVE, b, RESP_OKAY);
      rchk(OFS_FLAGS, i == 10 ? 12'h000 : b, RESP_OKAY);
      chk_flags(i == 10 ? 12'h000 : b);
      hold(12'h000, 5);
      chk_flags(b);
      rchk(OFS_FLAGS, b, RESP_OKAY);
      chk_flags(12'h000);
   endtask : flag_case

   task automatic giveVerdict;
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : giveVerdict

   initial
   begin
      #200us;
      errCount++;
      giveVerdict();
   end

   initial
   begin
      void'($urandom(46));
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      // With the reset pin high throughout, leaving reset must not look like a short pulse.
      hold(12'h000, 10);
      rchk(OFS_LIVE, 12'h000, RESP_OKAY);
      rchk(OFS_FLAGS, 12'h000, RESP_OKAY);
      rchk(OFS_FLAGS, 12'h000, RESP_OKAY);
      rchk(OFS_ENABLE, 12'hFFF, RESP_OKAY);
      for (int i = 0; i < NUM_FLAGS; i++) flag_case(i);
      @(posedge clk);
      {normalMode, lowPowerVddOnMode} <= 2'b00;
      hold(12'h180, 20);
      chk_flags(12'h000);
      hold(12'h000, 5);
      {normalMode, lowPowerVddOnMode} <= 2'b11;
      wchk(OFS_ENABLE, 12'hFFE, RESP_OKAY);
      hold(12'h001, 20);
      chk_flags(12'h000);
      hold(12'h000, 5);
      wchk(OFS_ENABLE, 12'hFFF, RESP_OKAY);
      wchk(OFS_FLAGS, 12'h123, RESP_SLVERR);
      rchk(8'h0C, 12'h000, RESP_SLVERR);
      repeat (5) @(posedge clk);
      errCount += host.timeouts + readQ.size() + respQ.size();
      giveVerdict();
   end
endmodule : regulator_fault_flag_latches_bench

`default_nettype wire
